// >>> shared/bpr_pkg.sv
// Constants, register map and carrier types for the bad pixel repair unit.
package bpr_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [31:0] BPR_ADDR_CONTROL = 32'hF1000298;
	localparam logic [31:0] BPR_ADDR_MEMORY = 32'hF100029C;
	localparam logic [31:0] BPR_ADDR_CAPABILITY = 32'hF10002A0;
	localparam logic [31:0] BPR_ADDR_LIST_DATA = 32'hF10002A4;

	// ----------------------------------------------------------------
	// Field positions (bit n of the word is hardware bit 31-n)
	// ----------------------------------------------------------------
	localparam int BPR_BIT_PRESENT = 31;
	localparam int BPR_BIT_BUILD_ERR = 30;
	localparam int BPR_BIT_BUILD_START = 26;
	localparam int BPR_BIT_ENABLE = 25;
	localparam int BPR_BIT_BUSY = 24;
	localparam int BPR_BIT_STORE_NV = 23;
	localparam int BPR_BIT_FETCH_NV = 22;
	localparam int BPR_BIT_CLEAR = 21;
	localparam int BPR_MEAN_LSB = 7;
	localparam int BPR_THR_LSB = 0;
	localparam int BPR_BIT_WR_ALLOW = 29;
	localparam int BPR_BIT_RD_ALLOW = 28;
	localparam int BPR_SIZE_LSB = 14;
	localparam int BPR_OFFSET_LSB = 0;
	localparam int BPR_FLOOR_LSB = 21;
	localparam int BPR_CEIL_LSB = 14;
	localparam int BPR_CAP_LSB = 0;

	// ----------------------------------------------------------------
	// Limits and reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] BPR_THRESHOLD_FLOOR = 7'h01;
	localparam logic [6:0] BPR_THRESHOLD_CEILING = 7'h7F;
	localparam logic [6:0] BPR_THRESHOLD_RESET = 7'h40;
	localparam logic [13:0] BPR_LIST_CAPACITY = 14'h0100;
	localparam logic [8:0] BPR_LIST_LIMIT = 9'h100;
	localparam logic [8:0] BPR_LIST_OVERFLOW = 9'h101;
	localparam logic [1:0] BPR_RESP_OKAY = 2'h0;
	localparam logic [1:0] BPR_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BPR_IDLE = 3'b000,
		BPR_ARM = 3'b001,
		BPR_BUILD = 3'b010,
		BPR_STORE = 3'b011,
		BPR_FETCH = 3'b100
	} bpr_state_e;

	typedef struct packed {
		logic valid;
		logic frame_start;
		logic [7:0] data;
	} bpr_pix_s;

endpackage

// >>> rtl/bpr_unit.sv
// Bad pixel repair unit: list build, correction, storage copy and AXI4-Lite registers.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Functional notes
// [RULE1] Correction and list building act only in the Format_7 Mode 0 video mode.
// [RULE2] A pixel is defective when its upper seven bits exceed the 7-bit threshold.
// [RULE3] Writing one to the build-start bit starts a new list construction.
// [RULE4] The busy bit stays high while a list construction is in progress.
// [RULE5] The enable bit switches correction of the image on and off.
// [RULE6] The store bit copies the current list into non-volatile storage.
// [RULE7] The fetch bit reloads the list from non-volatile storage.
// [RULE8] The clear bit empties the list so that no pixel is corrected.
// [RULE9] A calculated 7-bit image mean is reported in the control register.
// [RULE10] The list holds at most 256 entries.
// [RULE11] Over 256 defects sets list size to 257 and raises the build error.
// [RULE12] With overflow, only the first 256 entries found are used.
// [RULE13] The write-allow bit lets the host write list entries.
// [RULE14] The read-allow bit lets the host read list entries.
// [RULE15] The memory register reports the list size available to read.
// [RULE16] The memory register holds the offset of the entry being accessed.
// [RULE17] The capability register reports the threshold floor and ceiling.
// [RULE18] The capability register reports the list capacity.
// [RULE19] Bit 0 of each register reads as one, showing the feature exists; the list data register reads it as zero.
// [RULE20] Software selects binning or sub-sampling before enabling correction.
// [RULE21] Bits are numbered from the MSB, so bit 0 is word bit 31.
// [RULE22] On build completion, start and busy bits clear by themselves.
module bpr_unit
	import bpr_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Video path
	input wire logic fmt7_mode0,
	input wire bpr_pix_s pix_in,
	output bpr_pix_s pix_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bpr_state_e state_r;
	logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
	logic [31:0] aw_addr_r, w_data_r, rdata_r;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r, rresp_r;
	logic enable_r, build_err_r, wr_allow_r, rd_allow_r;
	logic [6:0] thr_r;
	logic [10:0] mean_acc_r;
	logic [8:0] count_r, nv_count_r, ptr_r;
	logic [13:0] offset_r;
	logic [7:0] copy_idx_r;
	logic [23:0] pix_idx_r;
	logic [7:0] prev_pix_r;
	bpr_pix_s pix_out_r;
	logic [23:0] list_ram [0:255];
	logic [23:0] nv_ram [0:255];

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire wr_go = aw_have_r && w_have_r && !bvalid_r;
	wire rd_go = s_axi_arvalid && !rvalid_r;
	wire wr_ctrl = wr_go && (aw_addr_r == BPR_ADDR_CONTROL);
	wire wr_mem = wr_go && (aw_addr_r == BPR_ADDR_MEMORY);
	wire wr_data = wr_go && (aw_addr_r == BPR_ADDR_LIST_DATA);
	wire wr_map = wr_ctrl || wr_mem || wr_data || (aw_addr_r == BPR_ADDR_CAPABILITY);
	wire rd_ctrl = s_axi_araddr == BPR_ADDR_CONTROL;
	wire rd_mem = s_axi_araddr == BPR_ADDR_MEMORY;
	wire rd_info = s_axi_araddr == BPR_ADDR_CAPABILITY;
	wire rd_data = s_axi_araddr == BPR_ADDR_LIST_DATA;
	wire rd_map = rd_ctrl || rd_mem || rd_info || rd_data;
	wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

	// ----------------------------------------------------------------
	// Register images, bit 0 of the map is word bit 31
	// ----------------------------------------------------------------
	wire busy = (state_r == BPR_ARM) || (state_r == BPR_BUILD); // RULE4 RULE22
	wire storing = state_r == BPR_STORE;
	wire fetching = state_r == BPR_FETCH;
	wire [6:0] mean = mean_acc_r[10:4];
	wire [31:0] ctrl_img = {1'b1, build_err_r, 3'h0, busy, enable_r, busy, storing, fetching,
		1'b0, 7'h00, mean, thr_r}; // RULE19 RULE21 RULE9
	wire [31:0] mem_img = {1'b1, 1'b0, wr_allow_r, rd_allow_r, 5'h00, count_r, offset_r}; // RULE15 RULE16
	wire [31:0] info_img = {1'b1, 3'h0, BPR_THRESHOLD_FLOOR, BPR_THRESHOLD_CEILING,
		BPR_LIST_CAPACITY}; // RULE17 RULE18
	wire [23:0] host_entry = rd_allow_r ? list_ram[offset_r[7:0]] : 24'h000000; // RULE14
	wire [31:0] data_img = {8'h00, host_entry};
	wire [31:0] rd_mux = rd_ctrl ? ctrl_img : rd_mem ? mem_img : rd_info ? info_img :
		rd_data ? data_img : 32'h00000000;
	wire [31:0] ctrl_w = (w_data_r & wmask) | (ctrl_img & ~wmask);
	wire [31:0] mem_w = (w_data_r & wmask) | (mem_img & ~wmask);
	wire [6:0] thr_w = ctrl_w[BPR_THR_LSB +: 7];
	wire [6:0] thr_nxt = (thr_w < BPR_THRESHOLD_FLOOR) ? BPR_THRESHOLD_FLOOR :
		(thr_w > BPR_THRESHOLD_CEILING) ? BPR_THRESHOLD_CEILING : thr_w; // RULE17
	wire cmd_ok = wr_ctrl && (state_r == BPR_IDLE);

	// ----------------------------------------------------------------
	// Pixel side decode
	// ----------------------------------------------------------------
	wire pv = pix_in.valid;
	wire fs = pix_in.valid && pix_in.frame_start;
	wire [23:0] cur_idx = fs ? 24'h000000 : pix_idx_r;
	wire [8:0] ptr_cur = fs ? 9'h000 : ptr_r;
	wire [8:0] used = (count_r > BPR_LIST_LIMIT) ? BPR_LIST_LIMIT : count_r; // RULE12
	wire defect = pix_in.data[7:1] > thr_r; // RULE2
	wire build_hit = pv && fmt7_mode0 && (state_r == BPR_BUILD) && !fs && defect;
	wire hit = pv && fmt7_mode0 && enable_r && (state_r == BPR_IDLE) && (ptr_cur < used) &&
		(list_ram[ptr_cur[7:0]] == cur_idx); // RULE1 RULE5
	wire host_wr = wr_data && wr_allow_r && (state_r == BPR_IDLE) &&
		(offset_r < BPR_LIST_CAPACITY); // RULE13
	wire host_rd = rd_go && rd_data && rd_allow_r;
	wire build_wr = build_hit && (count_r < BPR_LIST_LIMIT); // RULE10
	wire [7:0] ram_wa = fetching ? copy_idx_r : build_wr ? count_r[7:0] : offset_r[7:0];
	wire [23:0] ram_wd = fetching ? nv_ram[copy_idx_r] : build_wr ? cur_idx : w_data_r[23:0];
	wire ram_we = fetching || build_wr || host_wr;
	wire [8:0] host_cnt = {1'b0, offset_r[7:0]} + 9'h001;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign pix_out = pix_out_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 32'h00000000;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= BPR_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= BPR_RESP_OKAY;
		end else begin
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_map ? BPR_RESP_OKAY : BPR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= rd_map ? BPR_RESP_OKAY : BPR_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software controls
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_r <= 1'b0;
			thr_r <= BPR_THRESHOLD_RESET;
			wr_allow_r <= 1'b0;
			rd_allow_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				enable_r <= ctrl_w[BPR_BIT_ENABLE]; // RULE5
				thr_r <= thr_nxt; // RULE2
			end
			if (wr_mem) begin
				wr_allow_r <= mem_w[BPR_BIT_WR_ALLOW]; // RULE13
				rd_allow_r <= mem_w[BPR_BIT_RD_ALLOW]; // RULE14
			end
		end
	end

	// The offset steps after each allowed list data read or write so a whole list streams through one address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			offset_r <= 14'h0000;
		end else if (wr_mem) begin
			offset_r <= mem_w[BPR_OFFSET_LSB +: 14]; // RULE16
		end else if (host_wr || host_rd) begin
			offset_r <= offset_r + 14'h0001;
		end
	end

	// ----------------------------------------------------------------
	// List engine: build, store, fetch and clear
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= BPR_IDLE;
			count_r <= 9'h000;
			nv_count_r <= 9'h000;
			build_err_r <= 1'b0;
			copy_idx_r <= 8'h00;
		end else begin
			unique case (state_r)
				BPR_IDLE: begin
					copy_idx_r <= 8'h00;
					if (cmd_ok && ctrl_w[BPR_BIT_BUILD_START]) begin
						state_r <= BPR_ARM; // RULE3
					end else if (cmd_ok && ctrl_w[BPR_BIT_STORE_NV]) begin
						state_r <= BPR_STORE; // RULE6
					end else if (cmd_ok && ctrl_w[BPR_BIT_FETCH_NV]) begin
						state_r <= BPR_FETCH; // RULE7
					end else if (cmd_ok && ctrl_w[BPR_BIT_CLEAR]) begin
						count_r <= 9'h000; // RULE8
					end else if (host_wr && host_cnt > count_r) begin
						count_r <= host_cnt;
					end
				end
				BPR_ARM: begin
					if (fs && fmt7_mode0) begin
						state_r <= BPR_BUILD; // RULE1
						count_r <= 9'h000;
						build_err_r <= 1'b0;
					end
				end
				BPR_BUILD: begin
					if (fs || !fmt7_mode0) begin
						state_r <= BPR_IDLE; // RULE22
					end else if (build_hit && count_r != BPR_LIST_OVERFLOW) begin
						count_r <= count_r + 9'h001;
						if (count_r == BPR_LIST_LIMIT) begin
							build_err_r <= 1'b1; // RULE11
						end
					end
				end
				BPR_STORE: begin
					copy_idx_r <= copy_idx_r + 8'h01;
					nv_count_r <= count_r; // RULE6
					if (copy_idx_r == 8'hFF) begin
						state_r <= BPR_IDLE;
					end
				end
				BPR_FETCH: begin
					copy_idx_r <= copy_idx_r + 8'h01;
					count_r <= nv_count_r; // RULE7
					if (copy_idx_r == 8'hFF) begin
						state_r <= BPR_IDLE;
					end
				end
				default: begin
					state_r <= BPR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (ram_we) begin
			list_ram[ram_wa] <= ram_wd; // RULE10
		end
		if (storing) begin
			nv_ram[copy_idx_r] <= list_ram[copy_idx_r]; // RULE6
		end
	end

	// ----------------------------------------------------------------
	// Video path
	// ----------------------------------------------------------------
	// Entries are matched in ascending order, so lists written by the host must be sorted.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pix_idx_r <= 24'h000000;
			ptr_r <= 9'h000;
			prev_pix_r <= 8'h00;
			mean_acc_r <= 11'h000;
			pix_out_r <= '0;
		end else begin
			pix_out_r.valid <= pv;
			pix_out_r.frame_start <= fs;
			if (pv) begin
				pix_idx_r <= cur_idx + 24'h000001;
				ptr_r <= hit ? ptr_cur + 9'h001 : ptr_cur;
				prev_pix_r <= pix_in.data;
				pix_out_r.data <= hit ? prev_pix_r : pix_in.data; // RULE5 RULE12
				mean_acc_r <= mean_acc_r - {4'h0, mean} + {4'h0, pix_in.data[7:1]}; // RULE9
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_build_done;
		state_r == BPR_BUILD && fs;
	endsequence

	AST_MODE_GATE: assert property (pv && !fmt7_mode0 |=> pix_out_r.data == $past(pix_in.data)) // RULE1
		else $error("Correction acted outside the supported video mode.");
	AST_THR_RANGE: assert property (thr_r >= BPR_THRESHOLD_FLOOR && thr_r <= BPR_THRESHOLD_CEILING) // RULE2
		else $error("Threshold left its permitted range.");
	AST_START: assert property (cmd_ok && ctrl_w[BPR_BIT_BUILD_START] |=> busy ##0 ctrl_img[BPR_BIT_BUSY]) // RULE3
		else $error("Build start did not raise busy.");
	AST_BUSY_HOLD: assert property (state_r == BPR_BUILD && !fs && fmt7_mode0 |=> busy) // RULE4
		else $error("Busy fell during a build.");
	AST_DONE: assert property (s_build_done |=> !ctrl_img[BPR_BIT_BUSY] && !ctrl_img[BPR_BIT_BUILD_START]) // RULE22
		else $error("Build completion did not clear start and busy.");
	AST_CORRECT: assert property (hit |=> pix_out_r.data == $past(prev_pix_r)) // RULE5
		else $error("Listed pixel was not replaced.");
	AST_NO_CORRECT: assert property (pv && !enable_r |=> pix_out_r.data == $past(pix_in.data)) // RULE5
		else $error("Pixel altered while correction is off.");
	AST_CLEAR: assert property (cmd_ok && ctrl_w[BPR_BIT_CLEAR] && !ctrl_w[BPR_BIT_BUILD_START] &&
		!ctrl_w[BPR_BIT_STORE_NV] && !ctrl_w[BPR_BIT_FETCH_NV] |=> count_r == 9'h000) // RULE8
		else $error("Clear did not empty the list.");
	AST_CAP: assert property (count_r <= BPR_LIST_OVERFLOW) // RULE10
		else $error("List size passed the overflow mark.");
	AST_OVERFLOW: assert property (state_r == BPR_BUILD && count_r == BPR_LIST_OVERFLOW |-> build_err_r) // RULE11
		else $error("Overflow without build error.");
	AST_OVF_SET: assert property (build_hit && count_r == BPR_LIST_LIMIT |=> // RULE11
		build_err_r && count_r == BPR_LIST_OVERFLOW)
		else $error("Defect beyond capacity did not mark size and error.");
	AST_STORE_LEN: assert property ($rose(storing) |-> storing [*8]) // RULE6
		else $error("Storage copy ended too early.");
	AST_FETCH_LEN: assert property ($rose(fetching) |-> fetching [*8]) // RULE7
		else $error("Storage reload ended too early.");
	AST_ENABLE_WR: assert property (wr_ctrl |=> enable_r == $past(ctrl_w[BPR_BIT_ENABLE])) // RULE5
		else $error("Enable bit did not follow the control write.");
	AST_PRESENT: assert property (rd_go && rd_map && !rd_data |=> rdata_r[BPR_BIT_PRESENT]) // RULE19
		else $error("Presence flag read as zero.");
	AST_BHOLD: assert property (bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
		else $error("Write response dropped before acceptance.");

endmodule

// >>> sim/test_defect_pixel_correction.sv
// Self-checking testbench for the bad pixel repair unit.
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_defect_pixel_correction;
	import bpr_pkg::*;

	// ----------------------------------------------------------------
	// Signals and constants
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [31:0] m;
		logic [1:0] r;
	} bpr_row_s;
	localparam logic [31:0] C_ERR = 32'h40000000;
	localparam logic [31:0] C_START = 32'h04000000;
	localparam logic [31:0] C_EN = 32'h02000000;
	localparam logic [31:0] C_BUSY = 32'h01000000;
	localparam logic [31:0] C_STORE = 32'h00800000;
	localparam logic [31:0] C_FETCH = 32'h00400000;
	localparam logic [31:0] C_CLR = 32'h00200000;
	localparam logic [31:0] C_WRA = 32'h20000000;
	localparam logic [31:0] C_RDA = 32'h10000000;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fmt7_mode0 = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd;
	bpr_pix_s pix_in = '0;
	bpr_pix_s pix_out;
	int fails = 0;
	int check_count = 0;
	int cap_n = 0;
	logic [7:0] fr [0:299];
	logic [7:0] cap [0:299];
	bpr_row_s rows [0:7] = '{
		'{1'b0, BPR_ADDR_CONTROL, 32'h0, 32'h80000040, 32'hFFFFC07F, BPR_RESP_OKAY},
		'{1'b0, BPR_ADDR_MEMORY, 32'h0, 32'h80000000, 32'hFFFFFFFF, BPR_RESP_OKAY},
		'{1'b0, BPR_ADDR_CAPABILITY, 32'h0, 32'h803FC100, 32'hFFFFFFFF, BPR_RESP_OKAY},
		'{1'b1, BPR_ADDR_CAPABILITY, 32'h0, 32'h803FC100, 32'hFFFFFFFF, BPR_RESP_OKAY},
		'{1'b1, BPR_ADDR_CONTROL, 32'h0, 32'h80000001, 32'hFFFFC07F, BPR_RESP_OKAY},
		'{1'b1, BPR_ADDR_CONTROL, 32'h7F, 32'h8000007F, 32'hFFFFC07F, BPR_RESP_OKAY},
		'{1'b1, BPR_ADDR_MEMORY, 32'h5, 32'h80000005, 32'hFFFFFFFF, BPR_RESP_OKAY},
		'{1'b1, 32'hF10002B0, 32'h1, 32'h0, 32'hFFFFFFFF, BPR_RESP_SLVERR}
	};

	bpr_unit DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.fmt7_mode0(fmt7_mode0), .pix_in(pix_in), .pix_out(pix_out)
	);

	always #10 aclk = ~aclk;

	// Output pixels are captured at the falling edge, where they are settled.
	// The index restarts on the frame start flag, so a lost flag shows as a shifted capture.
	always @(negedge aclk) begin
		if (pix_out.valid === 1'b1 && pix_out.frame_start === 1'b1) cap_n = 0;
		if (pix_out.valid === 1'b1 && cap_n < 300) begin
			cap[cap_n] = pix_out.data;
			cap_n++;
		end
	end

	// ----------------------------------------------------------------
	// Bus and video tasks
	// ----------------------------------------------------------------
	// Handshakes are judged at the falling edge and acted on at the next rising edge.
	// Bready waits for bvalid, so the slave must hold its response for a cycle.
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw_h, w_h, b_h, b_v;
		n = 0;
		b_h = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!b_h && n < 200) begin
			@(negedge aclk);
			aw_h = (s_axi_awvalid & s_axi_awready) === 1'b1;
			w_h = (s_axi_wvalid & s_axi_wready) === 1'b1;
			b_h = (s_axi_bvalid & s_axi_bready) === 1'b1;
			b_v = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_h) s_axi_awvalid <= 1'b0;
			if (w_h) s_axi_wvalid <= 1'b0;
			if (b_h) s_axi_bready <= 1'b0;
			else if (b_v) s_axi_bready <= 1'b1;
			n++;
		end
		if (!b_h) fails++;
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar_h, r_h;
		n = 0;
		r_h = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_h && n < 200) begin
			@(negedge aclk);
			ar_h = (s_axi_arvalid & s_axi_arready) === 1'b1;
			r_h = (s_axi_rvalid & s_axi_rready) === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_h) s_axi_arvalid <= 1'b0;
			if (r_h) s_axi_rready <= 1'b0;
			n++;
		end
		if (!r_h) fails++;
	endtask

	// Store and fetch take hundreds of cycles, so completion is polled with a bound.
	task automatic wait_idle();
		int n;
		n = 0;
		rd = C_BUSY;
		while ((rd & (C_BUSY | C_STORE | C_FETCH)) !== 32'h0 && n < 400) begin
			axi_rd(BPR_ADDR_CONTROL, rd, rs);
			n++;
		end
		if (n >= 400) fails++;
	endtask

	task automatic send(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			pix_in <= '{valid: 1'b1, frame_start: (i == 0), data: fr[i]};
		end
		@(posedge aclk);
		pix_in <= '0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic corr(input logic m, input logic [31:0] c);
		fmt7_mode0 <= m;
		axi_wr(BPR_ADDR_CONTROL, c, rs);
		send(10);
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		#1000000;
		fails++;
		end_sim();
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[k]) begin
			if (rows[k].wr) begin
				axi_wr(rows[k].a, rows[k].d, rs);
				`CHK(rs, rows[k].r)
			end
			axi_rd(rows[k].a, rd, rs);
			`CHK(rd & rows[k].m, rows[k].e)
			`CHK(rs, rows[k].r)
		end
		// A build stays armed while the video mode is wrong.
		for (int i = 0; i < 10; i++) fr[i] = 8'h10;
		fr[0] = 8'hFF;
		fr[3] = 8'h22;
		fr[5] = 8'h21;
		fr[7] = 8'hFF;
		axi_wr(BPR_ADDR_CONTROL, C_START | 32'h10, rs);
		send(10);
		axi_rd(BPR_ADDR_CONTROL, rd, rs);
		`CHK(rd & (C_START | C_BUSY), C_START | C_BUSY)
		fmt7_mode0 <= 1'b1;
		send(10);
		send(1);
		wait_idle();
		`CHK(rd & (C_START | C_BUSY | C_ERR), 32'h0)
		axi_rd(BPR_ADDR_MEMORY, rd, rs);
		`CHK(rd[27:14], 14'h2)
		axi_wr(BPR_ADDR_MEMORY, C_RDA, rs);
		axi_rd(BPR_ADDR_LIST_DATA, rd, rs);
		`CHK(rd, 32'h3)
		axi_rd(BPR_ADDR_LIST_DATA, rd, rs);
		`CHK(rd, 32'h7)
		axi_rd(BPR_ADDR_MEMORY, rd, rs);
		`CHK(rd[13:0], 14'h2)
		// Correction replaces listed pixels by their predecessor.
		for (int i = 0; i < 10; i++) fr[i] = 8'(8'h10 + i);
		corr(1'b1, 32'h10);
		`CHK(cap[3], 8'h13)
		corr(1'b1, C_EN | 32'h10);
		`CHK(cap[3], 8'h12)
		`CHK(cap[5], 8'h15)
		`CHK(cap[7], 8'h16)
		corr(1'b0, C_EN | 32'h10);
		`CHK(cap[3], 8'h13)
		corr(1'b1, C_EN | C_CLR | 32'h10);
		`CHK(cap[3], 8'h13)
		axi_rd(BPR_ADDR_MEMORY, rd, rs);
		`CHK(rd[27:14], 14'h0)
		// Host-written list survives a store, clear and fetch.
		axi_wr(BPR_ADDR_MEMORY, C_WRA, rs);
		axi_wr(BPR_ADDR_LIST_DATA, 32'h4, rs);
		axi_rd(BPR_ADDR_MEMORY, rd, rs);
		`CHK(rd & 32'h0FFFFFFF, 32'h00004001)
		axi_wr(BPR_ADDR_CONTROL, C_STORE | 32'h10, rs);
		axi_rd(BPR_ADDR_CONTROL, rd, rs);
		`CHK(rd & C_STORE, C_STORE)
		wait_idle();
		axi_wr(BPR_ADDR_CONTROL, C_CLR | 32'h10, rs);
		axi_wr(BPR_ADDR_CONTROL, C_FETCH | 32'h10, rs);
		wait_idle();
		axi_rd(BPR_ADDR_MEMORY, rd, rs);
		`CHK(rd[27:14], 14'h1)
		corr(1'b1, C_EN | 32'h10);
		`CHK(cap[4], 8'h13)
		// Overflow: 299 defects against a capacity of 256.
		for (int i = 0; i < 300; i++) fr[i] = 8'hFF;
		axi_wr(BPR_ADDR_CONTROL, C_START | 32'h01, rs);
		send(300);
		send(1);
		wait_idle();
		`CHK(rd & C_ERR, C_ERR)
		`CHK(rd[13:7] >= 7'h70, 1'b1)
		axi_rd(BPR_ADDR_MEMORY, rd, rs);
		`CHK(rd[27:14], 14'h101)
		axi_wr(BPR_ADDR_MEMORY, C_RDA | 32'hFF, rs);
		axi_rd(BPR_ADDR_LIST_DATA, rd, rs);
		`CHK(rd, 32'h100)
		// A second reset in mid-run restores the defaults.
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(BPR_ADDR_CONTROL, rd, rs);
		`CHK(rd & 32'hFFFFC07F, 32'h80000040)
		axi_rd(BPR_ADDR_MEMORY, rd, rs);
		`CHK(rd, 32'h80000000)
		end_sim();
	end
endmodule
